// File: hw/exec_slice_pkg.sv
// Functional notes
// - low nibble over nine or half-carry adds six
// - high nibble plus half-carry and low-nibble overflow over nine, or carry, adds six
// - fixed 16-bit encoding, one cycle, carry only
// - decrement to W or file, five flags updated
// - extended set, a=0, f<=95 uses indexed offset
// - skip costs one, two or three extra cycles
// - skip discards fetched word as full no-op cycles
// - a=0 access bank, a=1 bank pointer chooses bank
`default_nettype none
package exec_slice_pkg;

  // ---------------------------------------------------------------
  // register map (apb byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // instr word, bit31 go, bit30 ext enable
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BANK   = 8'h0c;
  localparam logic [7:0] OFS_INFO   = 8'h10; // busy, skip, discard cycles pending
  localparam logic [7:0] OFS_FADDR  = 8'h14; // last effective file address
  localparam logic [7:0] OFS_FDATA  = 8'h18; // file memory window: index in [15:8]

  // ---------------------------------------------------------------
  // fields and encodings
  // ---------------------------------------------------------------
  localparam int CTRL_GO_BIT  = 31;
  localparam int CTRL_EXT_BIT = 30;
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;
  localparam int ST_N  = 4;
  localparam logic [15:0] ENC_BCD_FIXUP  = 16'h0007;
  localparam logic [5:0]  ENC_MINUS_ONE  = 6'h01;  // 0000 01da
  localparam logic [5:0]  ENC_MINUS_SKIP = 6'h0b;  // 0010 11da
  localparam logic [6:0]  ENC_CMP_LESS   = 7'h30;  // 0110 000a
  localparam logic [7:0]  INDEXED_LIMIT  = 8'h5f;
  localparam logic [3:0]  NIBBLE_MAX     = 4'h9;
  localparam logic [3:0]  NIBBLE_FIX     = 4'h6;
  localparam logic [3:0]  ACCESS_BANK    = 4'h0;
  localparam logic [1:0]  PH_WRITE       = 2'h3;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_FIXUP = 3'b001,
    OP_DEC   = 3'b010,
    OP_DECSZ = 3'b011,
    OP_CMPLT = 3'b100
  } op_t;

endpackage
`default_nettype wire

// File: hw/bcd_fixup_unit.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_fixup_unit
  import exec_slice_pkg::*;
(
  input  wire logic [7:0] acc_i,
  input  wire logic       carry_i,
  input  wire logic       half_i,
  output logic      [7:0] acc_o,
  output logic            carry_o
);
  logic [4:0] lo_sum;
  logic [4:0] hi_in;
  logic [4:0] hi_sum;

  // low nibble fix, then high nibble fed with half-carry
  always_comb begin
    if ((acc_i[3:0] > NIBBLE_MAX) || half_i) begin
      lo_sum = {1'b0, acc_i[3:0]} + {1'b0, NIBBLE_FIX};
    end else begin
      lo_sum = {1'b0, acc_i[3:0]};
    end
    // the low nibble's overflow moves up with the half-carry, else 0xce would give 0x24
    hi_in = {1'b0, acc_i[7:4]} + {4'h0, half_i} + {4'h0, lo_sum[4]};
    if ((hi_in > {1'b0, NIBBLE_MAX}) || carry_i) begin
      hi_sum = hi_in + {1'b0, NIBBLE_FIX};
    end else begin
      hi_sum = hi_in;
    end
    acc_o   = {hi_sum[3:0], lo_sum[3:0]};
    carry_o = hi_sum[4] | carry_i;
  end
endmodule
`default_nettype wire

// File: hw/exec_slice.sv
`timescale 1ns/1ps
`default_nettype none
module exec_slice
  import exec_slice_pkg::*;
#(
  parameter int FILE_DEPTH = 256
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  // only a 256-entry file fits the 8-bit file index
  if (FILE_DEPTH != 256) begin : g_depth_check
    $error("FILE_DEPTH must be 256");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  mem_ff [FILE_DEPTH];
  logic [7:0]  acc_ff;
  logic [4:0]  st_ff;
  logic [3:0]  bank_ff;
  logic [15:0] instr_ff;
  logic        ext_ff;
  logic [1:0]  nxtw_ff;   // words of the already fetched next instruction
  op_t         op_ff;
  logic [1:0]  ph_ff;     // q1..q4
  logic [1:0]  nop_ff;    // discard cycles pending
  logic        skip_ff;
  logic [7:0]  opnd_ff;
  logic [8:0]  res_ff;
  logic [11:0] faddr_ff;
  logic [31:0] rd_ff;
  logic        rdy_ff;
  logic        err_ff;

  logic        acc_go;
  logic        acc_wr;
  logic        wr_ctrl;
  logic [7:0]  fix_acc;
  logic        fix_c;
  logic        busy;
  logic [11:0] eff_addr;

  assign acc_go  = psel_i && penable_i && !rdy_ff;
  assign acc_wr  = acc_go && pwrite_i;
  assign wr_ctrl = acc_wr && (paddr_i == OFS_CTRL) && pwdata_i[CTRL_GO_BIT];
  assign busy    = (op_ff != OP_NONE) || (nop_ff != 2'h0);

  function automatic op_t decode(input logic [15:0] w);
    if (w == ENC_BCD_FIXUP) return OP_FIXUP;
    if (w[15:10] == ENC_MINUS_ONE) return OP_DEC;
    if (w[15:10] == ENC_MINUS_SKIP) return OP_DECSZ;
    if (w[15:9] == ENC_CMP_LESS) return OP_CMPLT;
    return OP_NONE;
  endfunction

  // effective address: access bank, indexed offset, or banked
  always_comb begin
    if (!instr_ff[8]) begin
      if (ext_ff && (instr_ff[7:0] <= INDEXED_LIMIT)) begin
        eff_addr = {4'h0, instr_ff[7:0] + acc_ff}; // offset from base, 8-bit window
      end else begin
        eff_addr = {ACCESS_BANK, instr_ff[7:0]};
      end
    end else begin
      eff_addr = {bank_ff, instr_ff[7:0]};
    end
  end

  bcd_fixup_unit u_fix (
    .acc_i   (acc_ff),
    .carry_i (st_ff[ST_C]),
    .half_i  (st_ff[ST_DC]),
    .acc_o   (fix_acc),
    .carry_o (fix_c)
  );

  // ---------------------------------------------------------------
  // four-phase sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_ff    <= OP_NONE;
      ph_ff    <= 2'h0;
      nop_ff   <= 2'h0;
      skip_ff  <= 1'b0;
      opnd_ff  <= 8'h00;
      res_ff   <= 9'h000;
      faddr_ff <= 12'h000;
    end else if (wr_ctrl && !busy) begin
      op_ff   <= decode(pwdata_i[15:0]);
      ph_ff   <= 2'h0;
      skip_ff <= 1'b0;
    end else if (op_ff != OP_NONE) begin
      ph_ff <= ph_ff + 2'h1;
      case (ph_ff)
        2'h1: begin // read operand in q2
          opnd_ff  <= mem_ff[eff_addr[7:0]];
          faddr_ff <= eff_addr;
        end
        2'h2: begin // process in q3
          res_ff <= {1'b0, opnd_ff} - 9'h001;
          if (op_ff == OP_CMPLT) skip_ff <= opnd_ff < acc_ff;
          if (op_ff == OP_DECSZ) skip_ff <= opnd_ff == 8'h01;
        end
        2'h3: begin
          op_ff <= OP_NONE;
          if (skip_ff) nop_ff <= nxtw_ff;
        end
        default: ;
      endcase
    end else if (nop_ff != 2'h0) begin
      ph_ff <= ph_ff + 2'h1;
      if (ph_ff == PH_WRITE) nop_ff <= nop_ff - 2'h1; // whole no-op cycles only
    end
  end

  // ---------------------------------------------------------------
  // writeback, file memory and software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_ff   <= 8'h00;
      st_ff    <= 5'h00;
      bank_ff  <= 4'h0;
      instr_ff <= 16'h0000;
      ext_ff   <= 1'b0;
      nxtw_ff  <= 2'h1;
    end else begin
      if (wr_ctrl && !busy) begin
        instr_ff <= pwdata_i[15:0];
        ext_ff   <= pwdata_i[CTRL_EXT_BIT];
        nxtw_ff  <= (pwdata_i[17:16] == 2'h0) ? 2'h1 : pwdata_i[17:16];
      end
      if (acc_wr && !busy && paddr_i == OFS_ACC) acc_ff <= pwdata_i[7:0];
      if (acc_wr && !busy && paddr_i == OFS_STATUS) st_ff <= pwdata_i[4:0];
      if (acc_wr && paddr_i == OFS_BANK) bank_ff <= pwdata_i[3:0];
      if (ph_ff == PH_WRITE && op_ff == OP_FIXUP) begin
        acc_ff      <= fix_acc;
        st_ff[ST_C] <= fix_c;
      end
      if (ph_ff == PH_WRITE && (op_ff == OP_DEC || op_ff == OP_DECSZ) && !instr_ff[9]) begin
        acc_ff <= res_ff[7:0];
      end
      if (ph_ff == PH_WRITE && op_ff == OP_DEC) begin
        st_ff[ST_C]  <= ~res_ff[8];
        st_ff[ST_DC] <= opnd_ff[3:0] != 4'h0;
        st_ff[ST_Z]  <= res_ff[7:0] == 8'h00;
        st_ff[ST_N]  <= res_ff[7];
        st_ff[ST_OV] <= opnd_ff == 8'h80;
      end
    end
  end

  // file memory has no reset, so it sits in a process of its own
  always_ff @(posedge clk_i) begin
    if (acc_wr && !busy && paddr_i == OFS_FDATA) mem_ff[pwdata_i[15:8]] <= pwdata_i[7:0];
    if (ph_ff == PH_WRITE && (op_ff == OP_DEC || op_ff == OP_DECSZ) && instr_ff[9]) begin
      mem_ff[faddr_ff[7:0]] <= res_ff[7:0];
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait state per access
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ff  <= 32'h0;
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      rdy_ff <= acc_go;
      err_ff <= 1'b0;
      if (acc_go) begin
        rd_ff <= 32'h0;
        case (paddr_i)
          OFS_CTRL:   rd_ff <= {1'b0, ext_ff, 12'h0, nxtw_ff, instr_ff};
          OFS_ACC:    rd_ff <= {24'h0, acc_ff};
          OFS_STATUS: rd_ff <= {27'h0, st_ff};
          OFS_BANK:   rd_ff <= {28'h0, bank_ff};
          OFS_INFO:   rd_ff <= {28'h0, nop_ff, skip_ff, busy};
          OFS_FADDR:  rd_ff <= {20'h0, faddr_ff};
          OFS_FDATA:  rd_ff <= {24'h0, mem_ff[pwdata_i[15:8]]};
          default:    err_ff <= 1'b1;
        endcase
      end
    end
  end

  assign prdata_o  = rd_ff;
  assign pready_o  = rdy_ff;
  assign pslverr_o = err_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_fixup_carry_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_ff == OP_FIXUP && ph_ff == PH_WRITE) |=> st_ff[4:1] == $past(st_ff[4:1]))
    else $error("fixup touched a flag other than carry");
  chk_fixup_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_ff == OP_FIXUP && ph_ff == 2'h0) |-> ##3 (ph_ff == PH_WRITE) ##1 (op_ff == OP_NONE))
    else $error("fixup not four phases");
  chk_cmp_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_ff == OP_CMPLT && ph_ff == PH_WRITE) |=> acc_ff == $past(acc_ff))
    else $error("compare wrote accumulator");
  sequence skip_end_s;
    (op_ff != OP_NONE) && ph_ff == PH_WRITE && skip_ff;
  endsequence
  chk_skip_nops: assert property (@(posedge clk_i) disable iff (rst_i)
    skip_end_s |=> nop_ff == $past(nxtw_ff))
    else $error("wrong discard count");
  chk_noskip_none: assert property (@(posedge clk_i) disable iff (rst_i)
    ((op_ff != OP_NONE) && ph_ff == PH_WRITE && !skip_ff) |=> nop_ff == 2'h0)
    else $error("discard without skip");
  chk_nop_length: assert property (@(posedge clk_i) disable iff (rst_i)
    (skip_end_s ##1 nop_ff == 2'h1) |-> busy [*4] ##1 !busy)
    else $error("single discard not four phases");
  chk_dec_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_ff == OP_DEC && ph_ff == PH_WRITE) |=> st_ff[ST_Z] == ($past(opnd_ff) == 8'h01))
    else $error("zero flag wrong");
  chk_dec_dest_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_ff == OP_DEC && ph_ff == PH_WRITE && !instr_ff[9]) |=> acc_ff == $past(opnd_ff) - 8'h01)
    else $error("decrement result not in accumulator");
  chk_bank_access: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_ff != OP_NONE && ph_ff == 2'h1 && !instr_ff[8] && !ext_ff) |=>
      faddr_ff[11:8] == ACCESS_BANK)
    else $error("access bank not used");
endmodule
`default_nettype wire

// File: test/apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// apb requester standing in for the core's fetch and pipeline control
module apb_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [7:0]  paddr_o,
  output logic      [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end

  // one transfer; held until pready is sampled, since the answer latency is the slave's
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i iff pready_i);
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines show the inverse so stale values never look valid
    pwrite_o <= ~wr;
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// File: test/byte_skip_decrement_bcd_adjust_tb.sv
`timescale 1ns/1ps
`default_nettype none
module byte_skip_decrement_bcd_adjust_tb;
  import exec_slice_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, f, v, d, r, s;
  logic [31:0] pwdata, prdata, q;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          el;
  // acc in, status in, acc out, status out
  logic [31:0] fix_tab [4] = '{32'ha5000501, 32'hce003401, 32'h12022802, 32'h991c991c};
  // file index, value, dest bit, result, flags
  logic [39:0] dec_tab [3] = '{40'h1001010007, 40'h2080007f09, 40'h210001ff10};
  // ext, bank bit, file index, pad, effective address
  logic [31:0] adr_tab [5] = '{32'h11300330, 32'h00300030, 32'h10300035, 32'h10600060,
                               32'h105f0064};

  exec_slice uut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr));
  apb_host_model host (
    .clk_i(clk_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic [31:0] rq;
    logic        re;
    host.xfer(1'b1, a, dat, rq, re);
  endtask
  // fdata reads carry only the byte, so the rest is masked
  task automatic chkreg(input string nm, input logic [7:0] a, input logic [7:0] idx,
                        input logic [31:0] exp);
    logic [31:0] rq;
    logic        re;
    host.xfer(1'b0, a, {16'h0, idx, 8'h00}, rq, re);
    chk(nm, rq & ((a == OFS_FDATA) ? 32'hff : 32'hffffffff), exp);
  endtask
  // start an op, then poll until idle; el is the elapsed cycle count
  task automatic run(input logic [15:0] ins, input logic ext, input logic [1:0] w);
    int t0;
    wr(OFS_CTRL, {1'b1, ext, 12'h0, w, ins});
    t0 = cyc;
    q = 32'h1;
    while (q[0] !== 1'b0) host.xfer(1'b0, OFS_INFO, 32'h0, q, e);
    el = cyc - t0;
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 4; i <= 12; i += 4) chkreg("reset_value", i[7:0], 8'h00, 32'h0);
    host.xfer(1'b0, 8'h1c, 32'h0, q, e);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    chk("unmapped_data", q, 32'h0);
    // decimal adjust, including a half-carry case and preserved flags
    foreach (fix_tab[i]) begin
      wr(OFS_ACC, {24'h0, fix_tab[i][31:24]});
      wr(OFS_STATUS, {24'h0, fix_tab[i][23:16]});
      run(ENC_BCD_FIXUP, 1'b0, 2'd1);
      // one four-phase cycle shows as 8 clocks with four-clock polling
      chk("fixup_time", {31'h0, el >= 8 && el < 12}, 32'h1);
      chkreg("fixup_acc", OFS_ACC, 8'h00, {24'h0, fix_tab[i][15:8]});
      chkreg("fixup_flags", OFS_STATUS, 8'h00, {24'h0, fix_tab[i][7:0]});
    end
    // plain decrement to either destination
    foreach (dec_tab[i]) begin
      {f, v, d, r, s} = dec_tab[i];
      wr(OFS_FDATA, {16'h0, f, v});
      wr(OFS_ACC, 32'h33);
      wr(OFS_STATUS, 32'h0);
      run({ENC_MINUS_ONE, d[0], 1'b0, f}, 1'b0, 2'd1);
      chkreg("dec_file", OFS_FDATA, f, {24'h0, d[0] ? r : v});
      chkreg("dec_acc", OFS_ACC, 8'h00, {24'h0, d[0] ? 8'h33 : r});
      chkreg("dec_flags", OFS_STATUS, 8'h00, {24'h0, s});
    end
    // compare skip for one, two and three word followers, then no skip
    wr(OFS_ACC, 32'h06);
    wr(OFS_FDATA, 32'h4005);
    for (int w = 1; w <= 3; w++) begin
      run({ENC_CMP_LESS, 1'b0, 8'h40}, 1'b0, w[1:0]);
      chk("skip_time", {31'h0, el >= 6 + 4 * w && el < 10 + 4 * w}, 32'h1);
      chkreg("cmp_file", OFS_FDATA, 8'h40, 32'h05);
      chkreg("cmp_info", OFS_INFO, 8'h00, 32'h2);
    end
    wr(OFS_FDATA, 32'h4006);
    run({ENC_CMP_LESS, 1'b0, 8'h40}, 1'b0, 2'd2);
    chk("noskip_time", {31'h0, el >= 8 && el < 12}, 32'h1);
    chkreg("noskip_info", OFS_INFO, 8'h00, 32'h0);
    chkreg("cmp_acc", OFS_ACC, 8'h00, 32'h06);
    // decrement-skip reaching zero keeps flags
    wr(OFS_FDATA, 32'h4101);
    wr(OFS_STATUS, 32'h15);
    run({ENC_MINUS_SKIP, 1'b1, 1'b0, 8'h41}, 1'b0, 2'd1);
    chk("decsz_time", {31'h0, el >= 10 && el < 14}, 32'h1);
    chkreg("decsz_file", OFS_FDATA, 8'h41, 32'h00);
    chkreg("decsz_flags", OFS_STATUS, 8'h00, 32'h15);
    // bank, access bank and indexed addressing around the limit
    wr(OFS_BANK, 32'h3);
    wr(OFS_ACC, 32'h05);
    foreach (adr_tab[i]) begin
      run({ENC_CMP_LESS, adr_tab[i][24], adr_tab[i][23:16]}, adr_tab[i][28], 2'd1);
      chkreg("eff_addr", OFS_FADDR, 8'h00, {20'h0, adr_tab[i][11:0]});
    end
    // control readback holds the last started word, its ext enable and follower size
    chkreg("ctrl_readback", OFS_CTRL, 8'h00, {2'b01, 12'h0, 2'd1, ENC_CMP_LESS, 9'h05f});
    finish_test();
  end
endmodule
`default_nettype wire
